// File: rtl/ldc_regs.vh
// Constants for the LED display command port
`ifndef LDC_REGS_VH
`define LDC_REGS_VH
// Command word field positions
`define LDC_MAIN_HI 15
`define LDC_MAIN_LO 14
`define LDC_SUB_HI 13
`define LDC_SUB_LO 12
`define LDC_BLUE_HI 11
`define LDC_BLUE_LO 8
`define LDC_GREEN_HI 7
`define LDC_GREEN_LO 4
`define LDC_RED_HI 3
`define LDC_RED_LO 0
`define LDC_CMD_RESET 16'h0000
// Mirror multiples for level codes 00..11
`define LDC_MULT_0 9'h000
`define LDC_MULT_1 9'h064
`define LDC_MULT_2 9'h0C8
`define LDC_MULT_3 9'h190
// Colour modulation: frame of 240 oscillator periods, 15 slots of 16
`define LDC_FRAME_DIV 240
`define LDC_SLOT_LEN 16
// Soft-start time in microseconds (1.2 ms)
`define LDC_SOFT_US 1200
`define LDC_CLK_MHZ 50
// Pump modes
`define LDC_PM_OFF 2'h0
`define LDC_PM_DIRECT 2'h1
`define LDC_PM_BOOST 2'h2
`endif

// File: rtl/ldc_command_port.v
// LED display command port: serial command, white levels, colour PWM, pump control
// Summary of operation
// - Serial data is sampled into the shift register on each shift clock rise.
// - Load strobe falling copies the shift register into the command register.
// - Shift register is static; any slow shift clock loses no data.
// - Bits 15:14 pick the current level of the four main outputs.
// - Bits 13:12 pick the current level of the two sub outputs.
// - Blue duty bits 11:8, green 7:4, red 3:0.
// - Level sets mirror multiple 400, 200, 100 or zero.
// - Level zero switches that display off entirely.
// - Enabling main or sub starts the pump in direct-connect mode, or in boost mode if force boost is high.
// - Dropout on any enabled one of the six white sources moves pump to boost.
// - With colour enable high, any nonzero colour duty keeps the pump running.
// - Boost current ramps linearly from zero to full over 1.2 ms.
// - Logic supply at ground forces shutdown whatever the command.
// - Colour enable lights colours; enable low and whites off means shutdown.
// - Force boost holds the pump in boost mode.
// - Colour frame is one 240th of the oscillator rate.
// - Duty code n gives n fifteenths on-time.
`timescale 1ns/100ps
`default_nettype none
`include "ldc_regs.vh"
module ldc_command_port #(
	parameter OSC_DIV = 62,
	parameter SOFT_CYC = `LDC_SOFT_US * `LDC_CLK_MHZ
) (
	// Clock and reset
	input wire clk,
	input wire rst,
	// Serial command pins
	input wire serial_data_in,
	input wire shift_clock,
	input wire load_strobe_n,
	// Control pins
	input wire color_enable,
	input wire force_boost,
	input wire logic_supply_ref,
	// Dropout flags of main 1-4 and sub 1-2
	input wire [5:0] dropout,
	// White outputs
	output reg [3:0] main_led_outputs,
	output reg [1:0] sub_led_outputs,
	output reg [8:0] main_mult,
	output reg [8:0] sub_mult,
	// Colour outputs
	output reg red_on,
	output reg green_on,
	output reg blue_on,
	// Pump state
	output reg [1:0] pump_mode,
	output reg [15:0] pump_strength,
	output reg shutdown,
	output reg [15:0] display_command_word
);
	// ****************************************
	// Input synchronisers
	// ****************************************
	reg [5:0] s1_r;
	reg [5:0] s2_r;
	reg sck_d_r;
	reg ld_d_r;
	reg [5:0] dr1_r;
	reg [5:0] dr2_r;
	// Two flops per asynchronous pin
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_r <= 6'h18; // Pin idle levels, no false edge
			s2_r <= 6'h18;
			sck_d_r <= 1'b1;
			ld_d_r <= 1'b1;
			dr1_r <= 6'h00;
			dr2_r <= 6'h00;
		end else begin
			s1_r <= {serial_data_in, shift_clock, load_strobe_n, color_enable,
				force_boost, logic_supply_ref};
			s2_r <= s1_r;
			sck_d_r <= s2_r[4];
			ld_d_r <= s2_r[3];
			dr1_r <= dropout;
			dr2_r <= dr1_r;
		end
	end
	wire din_s = s2_r[5];
	wire sck_s = s2_r[4];
	wire ld_s = s2_r[3];
	wire en_s = s2_r[2];
	wire boost_s = s2_r[1];
	wire vref_s = s2_r[0];
	wire sck_rise = sck_s & ~sck_d_r;
	wire ld_fall = ~ld_s & ld_d_r;

	// ****************************************
	// Shift and command registers
	// ****************************************
	reg [15:0] shift_r;
	// Static shift register; no timeout so slow clocks are fine
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_r <= `LDC_CMD_RESET;
			display_command_word <= `LDC_CMD_RESET;
		end else begin
			if (sck_rise)
				shift_r <= {shift_r[14:0], din_s};
			if (ld_fall)
				display_command_word <= shift_r;
		end
	end
	wire [1:0] main_lvl = display_command_word[`LDC_MAIN_HI:`LDC_MAIN_LO];
	wire [1:0] sub_lvl = display_command_word[`LDC_SUB_HI:`LDC_SUB_LO];
	wire [3:0] blue_d = display_command_word[`LDC_BLUE_HI:`LDC_BLUE_LO];
	wire [3:0] green_d = display_command_word[`LDC_GREEN_HI:`LDC_GREEN_LO];
	wire [3:0] red_d = display_command_word[`LDC_RED_HI:`LDC_RED_LO];

	// Level code to mirror multiple
	function [8:0] ldc_mult;
		input [1:0] lvl;
		begin
			case (lvl)
				2'h1: ldc_mult = `LDC_MULT_1;
				2'h2: ldc_mult = `LDC_MULT_2;
				2'h3: ldc_mult = `LDC_MULT_3;
				default: ldc_mult = `LDC_MULT_0;
			endcase
		end
	endfunction

	// Enables; a ground logic supply forces shutdown
	wire main_en = vref_s & (main_lvl != 2'h0);
	wire sub_en = vref_s & (sub_lvl != 2'h0);
	wire rgb_en = vref_s & en_s;
	wire rgb_any = rgb_en & ((red_d | green_d | blue_d) != 4'h0);
	wire off_nxt = ~(main_en | sub_en | rgb_en);

	// ****************************************
	// Pump oscillator and colour PWM
	// ****************************************
	reg [7:0] osc_cnt_r;
	reg [7:0] frame_r;
	wire osc_tick = (osc_cnt_r == OSC_DIV[7:0] - 8'h01);
	// Oscillator tick, frame of 240 ticks in 15 slots
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_cnt_r <= 8'h00;
			frame_r <= 8'h00;
		end else begin
			osc_cnt_r <= osc_tick ? 8'h00 : osc_cnt_r + 8'h01;
			if (osc_tick)
				frame_r <= (frame_r == `LDC_FRAME_DIV - 1) ? 8'h00 : frame_r + 8'h01;
		end
	end
	wire [3:0] slot = frame_r[7:4];

	// ****************************************
	// Charge pump controller
	// ****************************************
	// Forced boost request
	function force_boost_go;
		input b;
		begin
			force_boost_go = b;
		end
	endfunction
	reg [15:0] soft_cnt_r;
	localparam [15:0] SOFT_STEP = 16'hFFFF / SOFT_CYC[15:0];
	wire pump_need = main_en | sub_en | rgb_any;
	// Mode selection with soft-start ramp
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pump_mode <= `LDC_PM_OFF;
			soft_cnt_r <= 16'h0000;
			pump_strength <= 16'h0000;
		end else if (!pump_need) begin
			pump_mode <= `LDC_PM_OFF;
			soft_cnt_r <= 16'h0000;
			pump_strength <= 16'h0000;
		end else begin
			case (pump_mode)
				`LDC_PM_OFF: begin
					if (force_boost_go(boost_s))
						pump_mode <= `LDC_PM_BOOST;
					else
						pump_mode <= `LDC_PM_DIRECT;
				end
				`LDC_PM_DIRECT: begin
					if (boost_s | (|(dr2_r & {sub_en, sub_en, main_en, main_en, main_en,
						main_en})))
						pump_mode <= `LDC_PM_BOOST;
				end
				`LDC_PM_BOOST: begin
					if (soft_cnt_r < SOFT_CYC[15:0] - 16'h0001) begin
						soft_cnt_r <= soft_cnt_r + 16'h0001;
						pump_strength <= pump_strength + SOFT_STEP;
					end else
						pump_strength <= 16'hFFFF;
				end
				default: pump_mode <= `LDC_PM_OFF;
			endcase
		end
	end

	// ****************************************
	// Output registers
	// ****************************************
	// White and colour drive
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			main_led_outputs <= 4'h0;
			sub_led_outputs <= 2'h0;
			main_mult <= 9'h000;
			sub_mult <= 9'h000;
			red_on <= 1'b0;
			green_on <= 1'b0;
			blue_on <= 1'b0;
			shutdown <= 1'b1;
		end else begin
			main_led_outputs <= {4{main_en}};
			sub_led_outputs <= {2{sub_en}};
			main_mult <= main_en ? ldc_mult(main_lvl) : 9'h000;
			sub_mult <= sub_en ? ldc_mult(sub_lvl) : 9'h000;
			red_on <= rgb_en & (slot < red_d);
			green_on <= rgb_en & (slot < green_d);
			blue_on <= rgb_en & (slot < blue_d);
			shutdown <= off_nxt;
		end
	end
endmodule
`default_nettype wire

// File: test/ldc_props.sv
// Assertion checker for the LED display command port
`timescale 1ns/100ps
`default_nettype none
`include "ldc_regs.vh"
module ldc_props (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pins
	input wire logic color_enable,
	input wire logic force_boost,
	input wire logic logic_supply_ref,
	// Outputs
	input wire logic [3:0] main_led_outputs,
	input wire logic [8:0] main_mult,
	input wire logic [8:0] sub_mult,
	input wire logic [1:0] pump_mode,
	input wire logic [15:0] pump_strength,
	input wire logic shutdown,
	input wire logic [15:0] display_command_word
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic [15:0] w = display_command_word;
	// Level code to mirror multiple
	function automatic logic [8:0] mult(input logic [1:0] l);
		return l == 2'h0 ? 9'h000 : 9'h032 << l;
	endfunction
	// Word steady and display live
	sequence settled_s;
		$stable(w) [*3] ##0 !shutdown;
	endsequence
	// Pump leaves off with no forcing
	sequence wake_s;
		!force_boost [*5] ##0 ($past(pump_mode) == `LDC_PM_OFF && pump_mode != `LDC_PM_OFF);
	endsequence
	// Pump stayed in boost and ramp not yet full
	sequence boost_run_s;
		$past(pump_mode) == `LDC_PM_BOOST && $past(pump_strength) != 16'hFFFF
			&& pump_mode == `LDC_PM_BOOST;
	endsequence
	main_level_a: assert property (settled_s |-> main_mult == mult(w[15:14]))
		else $error("main level wrong");
	sub_level_a: assert property (settled_s |-> sub_mult == mult(w[13:12]))
		else $error("sub level wrong");
	main_off_a: assert property (
		settled_s ##0 w[15:14] == 2'h0 |-> main_led_outputs == 4'h0)
		else $error("main not off");
	supply_off_a: assert property (!logic_supply_ref [*6] |-> shutdown)
		else $error("no shutdown");
	boost_hold_a: assert property (
		(force_boost && !shutdown) [*6] |-> pump_mode == `LDC_PM_BOOST)
		else $error("boost not held");
	shut_pump_a: assert property (shutdown [*2] |-> pump_mode == `LDC_PM_OFF)
		else $error("pump on in shutdown");
	direct_first_a: assert property (wake_s |-> pump_mode == `LDC_PM_DIRECT)
		else $error("pump not direct");
	color_run_a: assert property (
		(color_enable && logic_supply_ref && w[11:0] != 12'h000) [*6]
		|-> pump_mode != `LDC_PM_OFF)
		else $error("pump idle");
	ramp_start_a: assert property (
		$changed(pump_mode) && pump_mode == `LDC_PM_BOOST |-> pump_strength == 16'h0000)
		else $error("ramp not from zero");
	ramp_rise_a: assert property (
		boost_run_s |-> pump_strength > $past(pump_strength))
		else $error("ramp not rising");
endmodule
bind ldc_command_port ldc_props i_props (.clk, .rst, .color_enable, .force_boost,
	.logic_supply_ref, .main_led_outputs, .main_mult, .sub_mult, .pump_mode, .pump_strength,
	.shutdown, .display_command_word);
`default_nettype wire

// File: test/ldc_host.sv
// Host model that shifts command words into the port
`timescale 1ns/100ps
`default_nettype none
module ldc_host (
	// Clock
	input wire logic clk,
	// Serial pins
	output var logic serial_data_in = 1'b0,
	output var logic shift_clock = 1'b1,
	output var logic load_strobe_n = 1'b1
);
	// Half of a 160 ns shift period
	task automatic half;
		repeat (4) @(posedge clk);
	endtask
	// Shift a word, then strobe it in
	task automatic send(input logic [15:0] w);
		@(posedge clk);
		for (int i = 15; i >= 0; i--) begin
			shift_clock <= 1'b0;
			serial_data_in <= w[i];
			half();
			shift_clock <= 1'b1;
			half();
		end
		serial_data_in <= ~w[0];
		load_strobe_n <= 1'b0;
		half();
		load_strobe_n <= 1'b1;
	endtask
endmodule
`default_nettype wire

// File: test/tb_led_display_command_port.sv
// Self-checking bench for the LED display command port
`timescale 1ns/100ps
`default_nettype none
`include "ldc_regs.vh"
module tb_led_display_command_port;
	localparam int OSC = 2;
	typedef struct {logic [15:0] w; logic [8:0] m; logic [8:0] s;} ldc_row_t;
	ldc_row_t rows [7] = '{'{16'h5123, 9'h064, 9'h064}, '{16'hA456, 9'h0C8, 9'h0C8},
		'{16'hF789, 9'h190, 9'h190}, '{16'h6FFF, 9'h064, 9'h0C8}, '{16'h9000, 9'h0C8, 9'h064},
		'{16'h3000, 9'h000, 9'h190}, '{16'h0000, 9'h000, 9'h000}};
	logic clk = 1'b0, rst = 1'b1, color_enable = 1'b0, force_boost = 1'b0;
	logic logic_supply_ref = 1'b1, red_on, green_on, blue_on, shutdown;
	logic serial_data_in, shift_clock, load_strobe_n;
	logic [5:0] dropout = 6'h00;
	logic [3:0] main_led_outputs;
	logic [1:0] sub_led_outputs, pump_mode;
	logic [8:0] main_mult, sub_mult;
	logic [15:0] pump_strength, display_command_word;
	int n_fail = 0, n_compared = 0, cyc = 0;
	logic [15:0] cr = 16'h0000, cg = 16'h0000, cb = 16'h0000;
	ldc_command_port #(.OSC_DIV(OSC), .SOFT_CYC(50)) i_dut (.clk, .rst, .serial_data_in,
		.shift_clock, .load_strobe_n, .color_enable, .force_boost, .logic_supply_ref, .dropout,
		.main_led_outputs, .sub_led_outputs, .main_mult, .sub_mult, .red_on, .green_on, .blue_on,
		.pump_mode, .pump_strength, .shutdown, .display_command_word);
	ldc_host i_host (.clk, .serial_data_in, .shift_clock, .load_strobe_n);
	// ****************
	// Helpers
	// ****************
	always #10 clk = ~clk;
	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		w(3);
		chk(pump_mode, `LDC_PM_OFF);
		chk(shutdown, 1'b1);
		for (int i = 0; i < 7; i++) begin
			i_host.send(rows[i].w);
			w(8);
			chk(display_command_word, rows[i].w);
			chk(main_mult, rows[i].m);
			chk(sub_mult, rows[i].s);
			chk({main_led_outputs, sub_led_outputs}, {{4{|rows[i].m}}, {2{|rows[i].s}}});
			chk(pump_mode, |{rows[i].m, rows[i].s} ? `LDC_PM_DIRECT : `LDC_PM_OFF);
		end
		i_host.send(16'h5000);
		dropout <= 6'h01;
		w(8);
		chk(pump_mode, `LDC_PM_BOOST);
		dropout <= 6'h00;
		logic_supply_ref <= 1'b0;
		w(8);
		chk(shutdown, 1'b1);
		logic_supply_ref <= 1'b1;
		w(8);
		chk(pump_mode, `LDC_PM_DIRECT);
		force_boost <= 1'b1;
		w(8);
		chk(pump_mode, `LDC_PM_BOOST);
		w(60);
		chk(pump_strength, 16'hFFFF);
		force_boost <= 1'b0;
		i_host.send(16'h0F80);
		color_enable <= 1'b1;
		w(500);
		chk(pump_mode == `LDC_PM_OFF, 1'b0);
		repeat (`LDC_FRAME_DIV * OSC) begin
			w(1);
			cr += red_on;
			cg += green_on;
			cb += blue_on;
		end
		chk(cr, 0);
		chk(cg, 8 * `LDC_SLOT_LEN * OSC);
		chk(cb, `LDC_FRAME_DIV * OSC);
		// Reset in mid-run, then a fresh command
		rst <= 1'b1;
		color_enable <= 1'b0;
		w(2);
		chk(shutdown, 1'b1);
		chk(pump_mode, `LDC_PM_OFF);
		rst <= 1'b0;
		w(3);
		chk(shutdown, 1'b1);
		chk(pump_strength, 16'h0000);
		i_host.send(16'hC000);
		w(8);
		chk(main_mult, `LDC_MULT_3);
		chk(pump_mode, `LDC_PM_DIRECT);
		complete_run();
	end
endmodule
`default_nettype wire
